//--- design/ata_command_acceptance.sv
// command acceptance and dispatch for the task-file interface
// Functional notes
// [RQ1] host writes commands only when not busy
// [RQ2] host loads parameters, then writes command last
// [RQ3] class one: busy within 400 ns
// [RQ4] class two: busy, data request within 700 us
// [RQ5] class three: data request within 20 ms
// [RQ6] legacy codes and 00h do nothing
// [RQ7] power query under two codes, drive only
// [RQ8] standby power query returns 00h count
// [RQ9] idle power query returns FFh count
// [RQ10] diagnostic code is class one, drive only
// [RQ11] card mode: diagnostic only on selected drive
// [RQ12] IDE mode: diagnostic ignores drive, combined status
// [RQ13] diagnostic result codes 01h to 03h
// [RQ14] result codes 04h, 05h, slave 8Xh
// [RQ15] erase is class one, full parameters
// [RQ16] erase moves no data, may fault
// [RQ17] host sets drive/head fixed bits for erase
// [RQ18] drive-only commands ignore head field
// [RQ19] standby and standby immediate decoded
// [RQ20] translate and wear level decoded class one
// [RQ21] write multiple variants are class three
// [RQ22] sector count zero means 256
// [RQ23] status read clears interrupt, alternate not
// [RQ24] unknown code ends in abort error
// [RQ25] command writes while busy are ignored
`timescale 1ns/1ps
module ata_command_acceptance #(
   parameter int unsigned C2_DRQ_CYCLES = cmd_accept_pkg::C2_DRQ_CYC,
   parameter int unsigned C3_DRQ_CYCLES = cmd_accept_pkg::C3_DRQ_CYC,
   parameter int unsigned PREP_CYCLES   = cmd_accept_pkg::PREP_CYC
) (
   input  wire logic       CLK_I,
   input  wire logic       RST_N_I,
   input  wire logic       CMD_WR_I,
   input  wire logic [7:0] CMD_CODE_I,
   input  wire logic [7:0] SEC_CNT_I,
   input  wire logic [7:0] DRV_HEAD_I,
   input  wire logic       CARD_ID_I,
   input  wire logic       IDE_MODE_I,
   input  wire logic       STANDBY_I,
   input  wire logic [7:0] SELF_TEST_I,
   input  wire logic       SLAVE_FAIL_I,
   input  wire logic [3:0] SLAVE_CODE_I,
   input  wire logic       ERASE_FAULT_I,
   input  wire logic       STATUS_RD_I,
   input  wire logic       ALT_STATUS_RD_I,
   output logic            CARD_BUSY_FLAG_O,
   output logic            DATA_REQUEST_FLAG_O,
   output logic            ERR_FLAG_O,
   output logic            WRITE_FAULT_O,
   output logic [7:0]      ERROR_REG_O,
   output logic [7:0]      SEC_CNT_O,
   output logic            SEC_CNT_WE_O,
   output logic [8:0]      XFER_SECTORS_O,
   output logic            BUF_PREP_O,
   output logic            ERASE_REQ_O,
   output logic            INTRQ_O
);
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_EXEC  = 6'b000010,
      ST_DIAG  = 6'b000100,
      ST_ERASE = 6'b001000,
      ST_PREP  = 6'b010000,
      ST_DROP  = 6'b100000
   } state_t;

   state_t                      state_q;
   cmd_accept_pkg::cmd_class_t  cls;
   cmd_accept_pkg::cmd_class_t  cls_q;
   logic [7:0]                  code_q;
   logic                        for_me_q;
   logic                        timer_load;
   logic [19:0]                 timer_count;
   logic                        timer_done;
   logic                        accept;

   default clocking dc @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   ////////////////////////////////////////////////////////////////////////////
   cmd_decode u_decode (
      .code_i (CMD_CODE_I),
      .cls_o  (cls)
   );

   cycle_timer #(.WIDTH(20)) u_timer (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .load_i  (timer_load),
      .count_i (timer_count),
      .done_o  (timer_done)
   );

   // a write seen while busy is still decoded, but it is never accepted into the sequencer
   assign accept = CMD_WR_I && !CARD_BUSY_FLAG_O; // RQ25 RQ1

   function automatic logic drive_hit(input logic [7:0] dh, input logic id);
      drive_hit = (dh[cmd_accept_pkg::DH_DRIVE_BIT] == id); // RQ18
   endfunction : drive_hit

   ////////////////////////////////////////////////////////////////////////////
   // timer loads: data request deadline is met early, with margin to spare
   always_comb begin
      timer_load  = 1'b0;
      timer_count = '0;
      if (accept && state_q == ST_IDLE) begin
         if (CMD_CODE_I == cmd_accept_pkg::CMD_DIAG) begin
            timer_load  = 1'b1;
            timer_count = 20'(cmd_accept_pkg::DIAG_CYC);
         end else if (CMD_CODE_I == cmd_accept_pkg::CMD_ERASE) begin
            timer_load  = 1'b1;
            timer_count = 20'(cmd_accept_pkg::ERASE_CYC);
         end else if (cls == cmd_accept_pkg::CLS_TWO || cls == cmd_accept_pkg::CLS_THREE) begin
            timer_load  = 1'b1;
            timer_count = 20'(PREP_CYCLES); // RQ4 RQ5
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer: busy comes up on the edge that takes the command
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         state_q  <= ST_IDLE;
         code_q   <= 8'h00;
         for_me_q <= 1'b0;
         cls_q    <= cmd_accept_pkg::CLS_NONE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (accept) begin
                  code_q   <= CMD_CODE_I;
                  cls_q    <= cls;
                  for_me_q <= IDE_MODE_I || drive_hit(DRV_HEAD_I, CARD_ID_I); // RQ11 RQ12
                  if (CMD_CODE_I == cmd_accept_pkg::CMD_DIAG) begin
                     state_q <= ST_DIAG;
                  end else if (CMD_CODE_I == cmd_accept_pkg::CMD_ERASE) begin
                     state_q <= ST_ERASE;
                  end else if (cls == cmd_accept_pkg::CLS_TWO || cls == cmd_accept_pkg::CLS_THREE) begin
                     state_q <= ST_PREP;
                  end else begin
                     state_q <= ST_EXEC;
                  end
               end
            end
            ST_EXEC:  state_q <= ST_IDLE;
            ST_DIAG:  if (timer_done) state_q <= ST_IDLE;
            ST_ERASE: if (timer_done) state_q <= ST_IDLE;
            ST_PREP:  if (timer_done) state_q <= ST_DROP;
            ST_DROP:  state_q <= ST_IDLE;
            default:  state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // busy and data request
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         CARD_BUSY_FLAG_O    <= 1'b0;
         DATA_REQUEST_FLAG_O <= 1'b0;
         BUF_PREP_O          <= 1'b0;
      end else begin
         if (accept) begin
            CARD_BUSY_FLAG_O    <= 1'b1; // RQ3
            DATA_REQUEST_FLAG_O <= 1'b0;
            BUF_PREP_O          <= (cls == cmd_accept_pkg::CLS_TWO || cls == cmd_accept_pkg::CLS_THREE);
         end else if (state_q == ST_PREP && timer_done) begin
            DATA_REQUEST_FLAG_O <= 1'b1; // RQ4 RQ5
            BUF_PREP_O          <= 1'b0;
         end else if (state_q == ST_DROP) begin
            CARD_BUSY_FLAG_O <= 1'b0; // RQ4 RQ5
         end else if (state_q == ST_EXEC || ((state_q == ST_DIAG || state_q == ST_ERASE) && timer_done)) begin
            CARD_BUSY_FLAG_O <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // results: error register, status error, write fault, sector count
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ERROR_REG_O    <= cmd_accept_pkg::ERR_RESET;
         ERR_FLAG_O     <= 1'b0;
         WRITE_FAULT_O  <= 1'b0;
         SEC_CNT_O      <= cmd_accept_pkg::SC_RESET;
         SEC_CNT_WE_O   <= 1'b0;
         XFER_SECTORS_O <= 9'h000;
         ERASE_REQ_O    <= 1'b0;
      end else begin
         SEC_CNT_WE_O <= 1'b0;
         ERASE_REQ_O  <= 1'b0;
         if (accept) begin
            ERR_FLAG_O     <= 1'b0;
            WRITE_FAULT_O  <= 1'b0;
            // a zero count asks for a full 256 sectors
            XFER_SECTORS_O <= (SEC_CNT_I == 8'h00) ? cmd_accept_pkg::SEC_FULL_COUNT : {1'b0, SEC_CNT_I}; // RQ22
            ERASE_REQ_O    <= (CMD_CODE_I == cmd_accept_pkg::CMD_ERASE); // RQ16
         end
         if (state_q == ST_EXEC) begin
            if (code_q == cmd_accept_pkg::CMD_PWR_CHK_A || code_q == cmd_accept_pkg::CMD_PWR_CHK_B) begin
               SEC_CNT_O    <= STANDBY_I ? cmd_accept_pkg::SC_STANDBY : cmd_accept_pkg::SC_IDLE; // RQ8 RQ9
               SEC_CNT_WE_O <= 1'b1;
            end else if (cls_q_none(code_q)) begin
               ERR_FLAG_O  <= 1'b1; // RQ24
               ERROR_REG_O <= cmd_accept_pkg::ERR_ABORT;
            end
         end
         if (state_q == ST_DIAG && timer_done && for_me_q) begin
            // master folds a failing slave into its own report
            if (IDE_MODE_I && SLAVE_FAIL_I) begin
               ERROR_REG_O <= cmd_accept_pkg::DIAG_SLAVE_ERR | {4'h0, SLAVE_CODE_I}; // RQ14 RQ12
            end else begin
               ERROR_REG_O <= SELF_TEST_I; // RQ13 RQ14
            end
         end
         if (state_q == ST_ERASE && timer_done) begin
            WRITE_FAULT_O <= ERASE_FAULT_I; // RQ16
            ERR_FLAG_O    <= ERASE_FAULT_I;
         end
      end
   end

   function automatic logic cls_q_none(input logic [7:0] c);
      cmd_accept_pkg::cmd_class_t k;
      k = cmd_accept_pkg::CLS_NONE;
      if (c[7:4] == cmd_accept_pkg::CMD_RECAL_HI || c[7:4] == cmd_accept_pkg::CMD_SEEK_HI) begin
         k = cmd_accept_pkg::CLS_ONE;
      end
      cls_q_none = (k == cmd_accept_pkg::CLS_NONE) && !known_code(c);
   endfunction : cls_q_none

   // legacy and unmodelled codes fall through as no-ops
   function automatic logic known_code(input logic [7:0] c);
      known_code = 1'b0;
      unique case (c)
         cmd_accept_pkg::CMD_NOP, cmd_accept_pkg::CMD_PWR_CHK_A, cmd_accept_pkg::CMD_PWR_CHK_B,
         cmd_accept_pkg::CMD_IDENT, cmd_accept_pkg::CMD_IDLE_A, cmd_accept_pkg::CMD_IDLE_B,
         cmd_accept_pkg::CMD_IDLE_IMM_A, cmd_accept_pkg::CMD_IDLE_IMM_B, cmd_accept_pkg::CMD_INIT_PARAM,
         cmd_accept_pkg::CMD_RD_BUF, cmd_accept_pkg::CMD_RD_DMA, cmd_accept_pkg::CMD_RD_MULT,
         cmd_accept_pkg::CMD_RD_SEC_A, cmd_accept_pkg::CMD_RD_SEC_B, cmd_accept_pkg::CMD_RD_VFY_A,
         cmd_accept_pkg::CMD_RD_VFY_B, cmd_accept_pkg::CMD_REQ_SENSE, cmd_accept_pkg::CMD_SET_FEAT,
         cmd_accept_pkg::CMD_SET_MULT, cmd_accept_pkg::CMD_SLEEP_A, cmd_accept_pkg::CMD_SLEEP_B,
         cmd_accept_pkg::CMD_STBY_A, cmd_accept_pkg::CMD_STBY_B, cmd_accept_pkg::CMD_STBY_IMM_A,
         cmd_accept_pkg::CMD_STBY_IMM_B, cmd_accept_pkg::CMD_XLATE, cmd_accept_pkg::CMD_WEAR:
            known_code = 1'b1; // RQ6 RQ19 RQ20
         default: ;
      endcase
   endfunction : known_code

   ////////////////////////////////////////////////////////////////////////////
   // interrupt: raised at completion, only a primary status read clears it
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         INTRQ_O <= 1'b0;
      end else if ((state_q == ST_EXEC) || (state_q == ST_DIAG && timer_done)
                   || (state_q == ST_ERASE && timer_done)) begin
         INTRQ_O <= 1'b1; // RQ8 RQ9
      end else if (STATUS_RD_I) begin
         INTRQ_O <= 1'b0; // RQ23
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   int unsigned drq_wait_q;
   int unsigned drq_limit;

   // class three may wait on sector reassignment, so it gets the longer limit
   assign drq_limit = (cls_q == cmd_accept_pkg::CLS_THREE) ? C3_DRQ_CYCLES : C2_DRQ_CYCLES;
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I || state_q != ST_PREP) begin
         drq_wait_q <= 0;
      end else begin
         drq_wait_q <= drq_wait_q + 1;
      end
   end

   a_busy_rise: assert property ( // RQ3
      accept |=> CARD_BUSY_FLAG_O)
      else $error("busy not raised after command write");

   a_busy_write_ignored: assert property ( // RQ25
      (CMD_WR_I && CARD_BUSY_FLAG_O && state_q != ST_IDLE) |=> $stable(code_q))
      else $error("command accepted while busy");

   a_drq_deadline: assert property ( // RQ4 RQ5
      drq_wait_q <= drq_limit)
      else $error("data request late");

   a_busy_drop: assert property ( // RQ4 RQ5
      $rose(DATA_REQUEST_FLAG_O) |-> ##[1:4] !CARD_BUSY_FLAG_O)
      else $error("busy not dropped after data request");

   a_pwr_standby: assert property ( // RQ8
      (state_q == ST_EXEC && code_q == cmd_accept_pkg::CMD_PWR_CHK_B && STANDBY_I)
      |=> SEC_CNT_WE_O && SEC_CNT_O == 8'h00 && !CARD_BUSY_FLAG_O && INTRQ_O)
      else $error("standby power query result wrong");

   a_pwr_idle: assert property ( // RQ9
      (state_q == ST_EXEC && code_q == cmd_accept_pkg::CMD_PWR_CHK_A && !STANDBY_I)
      |=> SEC_CNT_O == 8'hFF && INTRQ_O)
      else $error("idle power query result wrong");

   a_sector_full: assert property ( // RQ22
      (accept && SEC_CNT_I == 8'h00) |=> XFER_SECTORS_O == 9'h100)
      else $error("zero count not 256");

   a_alt_keeps_int: assert property ( // RQ23
      (INTRQ_O && ALT_STATUS_RD_I && !STATUS_RD_I) |=> INTRQ_O)
      else $error("alternate read cleared interrupt");

   a_unknown_abort: assert property ( // RQ24
      (accept && cls == cmd_accept_pkg::CLS_NONE) |=> ##1 ERR_FLAG_O && ERROR_REG_O == 8'h04)
      else $error("unknown code not aborted");

   a_diag_skip: assert property ( // RQ11
      (state_q == ST_DIAG && timer_done && !for_me_q) |=> $stable(ERROR_REG_O))
      else $error("diagnostic ran on unselected card");

   a_drq_cleared: assert property ( // RQ4 RQ5
      accept |=> !DATA_REQUEST_FLAG_O && !ERR_FLAG_O)
      else $error("new command left old flags");

   a_prep_shown: assert property ( // RQ4 RQ5
      (accept && (cls == cmd_accept_pkg::CLS_TWO || cls == cmd_accept_pkg::CLS_THREE)) |=> BUF_PREP_O)
      else $error("buffer preparation not shown");

   a_erase_pulse: assert property ( // RQ16
      (accept && CMD_CODE_I == cmd_accept_pkg::CMD_ERASE) |=> ERASE_REQ_O ##1 !ERASE_REQ_O)
      else $error("erase start not one pulse");

   a_diag_result: assert property ( // RQ13
      (state_q == ST_DIAG && timer_done && for_me_q && !SLAVE_FAIL_I) |=> ERROR_REG_O == $past(SELF_TEST_I))
      else $error("diagnostic result not reported");

   a_fault_report: assert property ( // RQ16
      (state_q == ST_ERASE && timer_done) |=> WRITE_FAULT_O == $past(ERASE_FAULT_I))
      else $error("erase fault not reported");

   a_intrq_clear: assert property ( // RQ23
      (STATUS_RD_I && state_q == ST_IDLE) |=> !INTRQ_O)
      else $error("status read kept interrupt");

   c_class_one: cover property (@(posedge CLK_I) accept && cls == cmd_accept_pkg::CLS_ONE);
   c_class_two: cover property (@(posedge CLK_I) accept && cls == cmd_accept_pkg::CLS_TWO);
   c_class_three: cover property (@(posedge CLK_I) accept && cls == cmd_accept_pkg::CLS_THREE);
   c_diag_done: cover property (@(posedge CLK_I) state_q == ST_DIAG && timer_done);
   c_unknown: cover property (@(posedge CLK_I) accept && cls == cmd_accept_pkg::CLS_NONE);
endmodule : ata_command_acceptance

//--- design/cmd_accept_pkg.sv
// package: command codes, classes, result codes and timing counts
package cmd_accept_pkg;
   // clock rate
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 100;
   // acceptance times as printed
   localparam int unsigned BUSY_SET_NS     = 400;
   localparam int unsigned BUSY_DROP_NS    = 400;
   localparam int unsigned C2_DRQ_US       = 700;
   localparam int unsigned C3_DRQ_MS       = 20;
   // busy times round down, never below one cycle
   localparam int unsigned BUSY_SET_CYC    = (BUSY_SET_NS / CLK_PERIOD_NS) < 1 ? 1 : BUSY_SET_NS / CLK_PERIOD_NS;
   localparam int unsigned BUSY_DROP_CYC   = (BUSY_DROP_NS / CLK_PERIOD_NS) < 1 ? 1 : BUSY_DROP_NS / CLK_PERIOD_NS;
   localparam int unsigned C2_DRQ_CYC      = C2_DRQ_US * (CLK_HZ / 1_000_000);
   localparam int unsigned C3_DRQ_CYC      = C3_DRQ_MS * (CLK_HZ / 1_000);
   // internal work times, plain defaults
   localparam int unsigned DIAG_CYC        = 16;
   localparam int unsigned ERASE_CYC       = 32;
   localparam int unsigned PREP_CYC        = 8;

   // command codes
   localparam logic [7:0] CMD_NOP          = 8'h00;
   localparam logic [7:0] CMD_PWR_CHK_A    = 8'h98;
   localparam logic [7:0] CMD_PWR_CHK_B    = 8'hE5;
   localparam logic [7:0] CMD_DIAG         = 8'h90;
   localparam logic [7:0] CMD_ERASE        = 8'hC0;
   localparam logic [7:0] CMD_IDENT        = 8'hEC;
   localparam logic [7:0] CMD_IDLE_A       = 8'hE3;
   localparam logic [7:0] CMD_IDLE_B       = 8'h97;
   localparam logic [7:0] CMD_IDLE_IMM_A   = 8'hE1;
   localparam logic [7:0] CMD_IDLE_IMM_B   = 8'h95;
   localparam logic [7:0] CMD_INIT_PARAM   = 8'h91;
   localparam logic [7:0] CMD_RD_BUF       = 8'hE4;
   localparam logic [7:0] CMD_RD_DMA       = 8'hC8;
   localparam logic [7:0] CMD_RD_MULT      = 8'hC4;
   localparam logic [7:0] CMD_RD_SEC_A     = 8'h20;
   localparam logic [7:0] CMD_RD_SEC_B     = 8'h21;
   localparam logic [7:0] CMD_RD_VFY_A     = 8'h40;
   localparam logic [7:0] CMD_RD_VFY_B     = 8'h41;
   localparam logic [3:0] CMD_RECAL_HI     = 4'h1;
   localparam logic [7:0] CMD_REQ_SENSE    = 8'h03;
   localparam logic [3:0] CMD_SEEK_HI      = 4'h7;
   localparam logic [7:0] CMD_SET_FEAT     = 8'hEF;
   localparam logic [7:0] CMD_SET_MULT     = 8'hC6;
   localparam logic [7:0] CMD_SLEEP_A      = 8'hE6;
   localparam logic [7:0] CMD_SLEEP_B      = 8'h99;
   localparam logic [7:0] CMD_STBY_A       = 8'hE2;
   localparam logic [7:0] CMD_STBY_B       = 8'h96;
   localparam logic [7:0] CMD_STBY_IMM_A   = 8'hE0;
   localparam logic [7:0] CMD_STBY_IMM_B   = 8'h94;
   localparam logic [7:0] CMD_XLATE        = 8'h87;
   localparam logic [7:0] CMD_WEAR         = 8'hF5;
   localparam logic [7:0] CMD_WR_BUF       = 8'hE8;
   localparam logic [7:0] CMD_WR_DMA       = 8'hCA;
   localparam logic [7:0] CMD_WR_MULT      = 8'hC5;
   localparam logic [7:0] CMD_WR_MULT_NE   = 8'hCD;
   localparam logic [7:0] CMD_WR_SEC_A     = 8'h30;
   localparam logic [7:0] CMD_WR_SEC_B     = 8'h31;
   localparam logic [7:0] CMD_WR_SEC_NE    = 8'h38;
   localparam logic [7:0] CMD_WR_VFY       = 8'h3C;

   // command classes
   typedef enum logic [1:0] {
      CLS_NONE = 2'h0,
      CLS_ONE  = 2'h1,
      CLS_TWO  = 2'h2,
      CLS_THREE = 2'h3
   } cmd_class_t;

   // results
   localparam logic [7:0] SC_STANDBY       = 8'h00;
   localparam logic [7:0] SC_IDLE          = 8'hFF;
   localparam logic [7:0] DIAG_OK          = 8'h01;
   localparam logic [7:0] DIAG_FMT_ERR     = 8'h02;
   localparam logic [7:0] DIAG_BUF_ERR     = 8'h03;
   localparam logic [7:0] DIAG_ECC_ERR     = 8'h04;
   localparam logic [7:0] DIAG_CPU_ERR     = 8'h05;
   localparam logic [7:0] DIAG_SLAVE_ERR   = 8'h80;
   localparam logic [7:0] ERR_ABORT        = 8'h04;
   localparam logic [7:0] ERR_RESET        = 8'h00;
   localparam logic [7:0] SC_RESET         = 8'h01;
   localparam int unsigned DH_DRIVE_BIT    = 4;
   localparam logic [8:0] SEC_FULL_COUNT   = 9'h100;
endpackage : cmd_accept_pkg

//--- design/cmd_decode.sv
// command code classifier
`timescale 1ns/1ps
module cmd_decode (
   input  wire logic [7:0]                code_i,
   output cmd_accept_pkg::cmd_class_t     cls_o
);
   function automatic cmd_accept_pkg::cmd_class_t classify(input logic [7:0] c);
      classify = cmd_accept_pkg::CLS_NONE;
      if (c[7:4] == cmd_accept_pkg::CMD_RECAL_HI || c[7:4] == cmd_accept_pkg::CMD_SEEK_HI) begin
         classify = cmd_accept_pkg::CLS_ONE;
      end
      unique case (c)
         cmd_accept_pkg::CMD_NOP, // RQ6
         cmd_accept_pkg::CMD_PWR_CHK_A, cmd_accept_pkg::CMD_PWR_CHK_B, // RQ7
         cmd_accept_pkg::CMD_DIAG, // RQ10
         cmd_accept_pkg::CMD_ERASE, // RQ15
         cmd_accept_pkg::CMD_IDENT, cmd_accept_pkg::CMD_IDLE_A, cmd_accept_pkg::CMD_IDLE_B,
         cmd_accept_pkg::CMD_IDLE_IMM_A, cmd_accept_pkg::CMD_IDLE_IMM_B, cmd_accept_pkg::CMD_INIT_PARAM,
         cmd_accept_pkg::CMD_RD_BUF, cmd_accept_pkg::CMD_RD_DMA, cmd_accept_pkg::CMD_RD_MULT,
         cmd_accept_pkg::CMD_RD_SEC_A, cmd_accept_pkg::CMD_RD_SEC_B, cmd_accept_pkg::CMD_RD_VFY_A,
         cmd_accept_pkg::CMD_RD_VFY_B, cmd_accept_pkg::CMD_REQ_SENSE, cmd_accept_pkg::CMD_SET_FEAT,
         cmd_accept_pkg::CMD_SET_MULT, cmd_accept_pkg::CMD_SLEEP_A, cmd_accept_pkg::CMD_SLEEP_B,
         cmd_accept_pkg::CMD_STBY_A, cmd_accept_pkg::CMD_STBY_B, // RQ19
         cmd_accept_pkg::CMD_STBY_IMM_A, cmd_accept_pkg::CMD_STBY_IMM_B, // RQ19
         cmd_accept_pkg::CMD_XLATE, cmd_accept_pkg::CMD_WEAR: // RQ20
            classify = cmd_accept_pkg::CLS_ONE;
         cmd_accept_pkg::CMD_WR_BUF, cmd_accept_pkg::CMD_WR_DMA, cmd_accept_pkg::CMD_WR_SEC_A,
         cmd_accept_pkg::CMD_WR_SEC_B, cmd_accept_pkg::CMD_WR_SEC_NE:
            classify = cmd_accept_pkg::CLS_TWO;
         cmd_accept_pkg::CMD_WR_MULT, cmd_accept_pkg::CMD_WR_MULT_NE, // RQ21
         cmd_accept_pkg::CMD_WR_VFY:
            classify = cmd_accept_pkg::CLS_THREE;
         default: ;
      endcase
   endfunction : classify

   assign cls_o = classify(code_i);
endmodule : cmd_decode

//--- design/cycle_timer.sv
// loadable down counter with done pulse
`timescale 1ns/1ps
module cycle_timer #(
   parameter int unsigned WIDTH = 20
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] count_i,
   output logic                  done_o
);
   logic [WIDTH-1:0] cnt_q;
   logic             run_q;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt_q  <= '0;
         run_q  <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (load_i) begin
            cnt_q <= count_i;
            run_q <= 1'b1;
         end else if (run_q) begin
            if (cnt_q <= 1) begin
               run_q  <= 1'b0;
               done_o <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
         end
      end
   end
endmodule : cycle_timer

//--- bench/ata_host_model.sv
// host model: loads the task file, then writes the command code
`timescale 1ns/1ps
module ata_host_model (
   input  wire logic       clk_i,
   input  wire logic       go_i,
   input  wire logic       bad_i,
   input  wire logic       busy_i,
   input  wire logic [7:0] code_i,
   input  wire logic [7:0] sc_i,
   input  wire logic [7:0] dh_i,
   output logic            wr_o,
   output logic [7:0]      code_o,
   output logic [7:0]      sc_o,
   output logic [7:0]      dh_o
);
   logic loaded = 1'b0;
   initial {wr_o, code_o, sc_o, dh_o} = 25'h0;
   always @(posedge clk_i) begin
      #5;
      wr_o = loaded && (!busy_i || bad_i);
      if (wr_o) begin
         code_o = code_i;
         loaded = 1'b0;
      end else if (go_i && !loaded) begin
         sc_o = sc_i;
         dh_o = dh_i;
         loaded = 1'b1;
      end else if (!loaded) begin
         // lines wander when idle so stale values are never trusted
         {code_o, sc_o, dh_o} = ~{code_o, sc_o, dh_o};
      end
   end
endmodule : ata_host_model

//--- bench/ata_command_acceptance_test.sv
// self-checking bench for command acceptance
`timescale 1ns/1ps
module ata_command_acceptance_test;
   logic       clk = 1'b0, rst_n = 1'b0, go = 1'b0, bad = 1'b0, ide = 1'b0, stby = 1'b0;
   logic       sfail = 1'b0, efault = 1'b0, srd = 1'b0, ard = 1'b0, wr, busy, data_request_flag, err, wf, sc_we, prep, erq, irq;
   logic [7:0] code = 8'h00, sc = 8'h00, dh = 8'hA0, stest = 8'h01, code_w, sc_w, dh_w, err_reg, sc_o;
   logic [3:0] scode = 4'h0;
   logic [8:0] xfer;
   logic [1:0] seen;
   logic [31:0] rng = 32'h36;
   int         err_total = 0, n_compared = 0, drq_n;
   logic [7:0] c1[7] = '{8'h00, 8'hE2, 8'h96, 8'hE0, 8'h94, 8'h87, 8'hF5};
   logic [7:0] c23[3] = '{8'hC5, 8'hCD, 8'h30};
   ata_host_model ata_host_model_inst (.clk_i(clk), .go_i(go), .bad_i(bad), .busy_i(busy), .code_i(code),
      .sc_i(sc), .dh_i(dh), .wr_o(wr), .code_o(code_w), .sc_o(sc_w), .dh_o(dh_w));
   // short prep keeps class two and three runs brief
   ata_command_acceptance #(.PREP_CYCLES(2)) ata_command_acceptance_inst (.CLK_I(clk), .RST_N_I(rst_n),
      .CMD_WR_I(wr), .CMD_CODE_I(code_w), .SEC_CNT_I(sc_w), .DRV_HEAD_I(dh_w), .CARD_ID_I(1'b0),
      .IDE_MODE_I(ide), .STANDBY_I(stby), .SELF_TEST_I(stest), .SLAVE_FAIL_I(sfail), .SLAVE_CODE_I(scode),
      .ERASE_FAULT_I(efault), .STATUS_RD_I(srd), .ALT_STATUS_RD_I(ard), .CARD_BUSY_FLAG_O(busy),
      .DATA_REQUEST_FLAG_O(data_request_flag), .ERR_FLAG_O(err), .WRITE_FAULT_O(wf), .ERROR_REG_O(err_reg),
      .SEC_CNT_O(sc_o), .SEC_CNT_WE_O(sc_we), .XFER_SECTORS_O(xfer), .BUF_PREP_O(prep), .ERASE_REQ_O(erq),
      .INTRQ_O(irq));
   //////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction : rnd
   function automatic logic [8:0] exp_xfer(input logic [7:0] s);
      return (s == 8'h00) ? 9'h100 : {1'b0, s};
   endfunction : exp_xfer
   task automatic chk(input logic [8:0] seen_v, input logic [8:0] exp_v);
      n_compared++;
      if (seen_v !== exp_v) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen_v, exp_v);
      end
   endtask : chk
   task automatic step();
      @(posedge clk);
      #10;
   endtask : step
   task automatic issue(input logic [7:0] c);
      code = c;
      go = 1'b1;
      for (int n = 0; n < 50 && wr !== 1'b1; n++) step();
      go = 1'b0;
   endtask : issue
   task automatic finish();
      seen = 2'h0;
      drq_n = 0;
      step();
      chk(busy, 1'b1);
      for (int n = 0; n < 300 && busy !== 1'b0; n++) begin
         seen = seen | {erq, prep};
         if (data_request_flag === 1'b1) drq_n++;
         step();
      end
      chk(busy, 1'b0);
   endtask : finish
   task automatic run(input logic [7:0] c);
      issue(c);
      finish();
   endtask : run
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   //////////////////////////////////////////////////////////////////////////////
   initial forever #50 clk = ~clk;
   initial begin
      #2_000_000;
      err_total++;
      stop_test();
   end
   initial begin
      repeat (6) step();
      rst_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         stby = i[0];
         dh = {4'hA, 4'(rnd())};
         run(i[1] ? 8'hE5 : 8'h98);
         chk(sc_we, 1'b1);
         chk(sc_o, stby ? 8'h00 : 8'hFF);
      end
      ard = 1'b1;
      step();
      ard = 1'b0;
      chk(irq, 1'b1);
      srd = 1'b1;
      step();
      srd = 1'b0;
      chk(irq, 1'b0);
      $display("test power query done");
      foreach (c1[i]) begin
         run(c1[i]);
         chk(err, 1'b0);
      end
      run(8'h5A);
      chk({err, err_reg}, 9'h104);
      $display("test decode done");
      for (int t = 1; t <= 5; t++) begin
         stest = t[7:0];
         dh = {4'hE, 4'(rnd())};
         run(8'h90);
         chk(err_reg, t[8:0]);
      end
      dh = 8'hF0;
      stest = 8'h02;
      run(8'h90);
      chk(err_reg, 9'h005);
      ide = 1'b1;
      sfail = 1'b1;
      scode = 4'(rnd());
      run(8'h90);
      chk(err_reg, {5'h08, scode});
      ide = 1'b0;
      sfail = 1'b0;
      $display("test diagnostic done");
      efault = 1'b1;
      sc = rnd();
      dh = {4'hE, 4'(rnd())};
      run(8'hC0);
      chk({seen[1], wf, err}, 9'h007);
      efault = 1'b0;
      for (int i = 0; i < 6; i++) begin
         sc = (i == 0) ? 8'h00 : rnd();
         run(c23[i % 3]);
         chk({seen[0], data_request_flag, drq_n[0]}, 9'h007);
         chk(xfer, exp_xfer(sc));
      end
      issue(8'hC0);
      repeat (3) step();
      bad = 1'b1;
      issue(8'h5A);
      bad = 1'b0;
      finish();
      chk({err, wf}, 9'h000);
      $display("test erase and write done");
      stop_test();
   end
endmodule : ata_command_acceptance_test
